// File: logic/tdda_pkg.sv
// shared constants and types for the two-dimensional dma address sequencer
package tdda_pkg;

  // datapath widths
  localparam int unsigned TDDA_ADDR_W = 19;   // internal memory address width
  localparam int unsigned TDDA_CNT_W  = 16;   // element and row count width
  localparam int unsigned TDDA_DATA_W = 32;   // register port data width
  localparam int unsigned TDDA_REG_AW = 4;    // register port address width

  // highest channel number that offers two-dimensional addressing
  localparam int unsigned TDDA_LAST_2D_CHAN = 5;
  // channels from this number up belong to the link buffers
  localparam int unsigned TDDA_FIRST_LINK_CHAN = 4;

  // register word offsets on the plain register port
  localparam logic [3:0] TDDA_OFF_INDEX  = 4'h0;   // index_address
  localparam logic [3:0] TDDA_OFF_XSTEP  = 4'h1;   // x_step_offset
  localparam logic [3:0] TDDA_OFF_XCNT   = 4'h2;   // working element count of the row
  localparam logic [3:0] TDDA_OFF_XRELD  = 4'h3;   // x_reload_value
  localparam logic [3:0] TDDA_OFF_YSTEP  = 4'h4;   // y_step_offset
  localparam logic [3:0] TDDA_OFF_ROWS   = 4'h5;   // rows_left
  localparam logic [3:0] TDDA_OFF_NPTR   = 4'h6;   // next_param_pointer, write starts block
  localparam logic [3:0] TDDA_OFF_CTRL   = 4'h7;   // mode bits
  localparam logic [3:0] TDDA_OFF_STATUS = 4'h8;   // sequencer state, read only

  // field positions
  localparam int unsigned TDDA_CTRL_LINK_2D_BIT  = 0;   // link_two_dim_enable
  localparam int unsigned TDDA_CTRL_SPORT_2D_BIT = 1;   // sport_two_dim_enable
  localparam int unsigned TDDA_STAT_ACTIVE_BIT   = 0;   // block in progress
  localparam int unsigned TDDA_STAT_ROWCHG_BIT   = 1;   // row-change cycle pending

  // reset values
  localparam logic [TDDA_ADDR_W-1:0] TDDA_RST_ADDR = 19'h0_0000;
  localparam logic [TDDA_CNT_W-1:0]  TDDA_RST_CNT  = 16'h0000;
  localparam logic [TDDA_DATA_W-1:0] TDDA_RST_DATA = 32'h0000_0000;

  // sequencer phase
  typedef enum logic [1:0] {
    TDDA_IDLE,
    TDDA_ELEM,
    TDDA_ROWCHG
  } tdda_phase_t;

  // whole state of one channel
  typedef struct packed {
    logic [TDDA_ADDR_W-1:0] index_address;
    logic [TDDA_ADDR_W-1:0] x_step_offset;
    logic [TDDA_CNT_W-1:0]  x_count;
    logic [TDDA_CNT_W-1:0]  x_reload_value;
    logic [TDDA_ADDR_W-1:0] y_step_offset;
    logic [TDDA_CNT_W-1:0]  rows_left;
    logic [TDDA_ADDR_W-1:0] next_param_pointer;
    logic                   link_two_dim_enable;
    logic                   sport_two_dim_enable;
    tdda_phase_t            phase;
    logic [TDDA_ADDR_W-1:0] mem_addr;
    logic                   mem_cycle;
    logic                   row_cycle;
    logic                   block_done;
    logic                   dma_req;
    logic [TDDA_DATA_W-1:0] rdata;
  } tdda_state_t;

endpackage

// File: logic/tdda_step.sv
`timescale 1ns/100ps
// one adder and one decrementer, shared by the element and row-change cycles
module tdda_step
  import tdda_pkg::*;
(
  input  wire logic [TDDA_ADDR_W-1:0] base,      // current address
  input  wire logic [TDDA_ADDR_W-1:0] step,      // offset to add
  input  wire logic [TDDA_CNT_W-1:0]  count,     // count to decrement
  output logic      [TDDA_ADDR_W-1:0] sum,       // base plus step, wraps
  output logic      [TDDA_CNT_W-1:0]  count_dec, // count minus one, wraps
  output logic                        dec_zero   // decremented count is zero
);

  // wrap-around arithmetic: a zero count decrements to all ones, so the
  // transfer still runs instead of being suppressed
  always_comb begin
    sum       = base + step;
    count_dec = count - 16'h0001;
    dec_zero  = (count_dec == TDDA_RST_CNT);
  end

endmodule

// File: logic/tdda_chan.sv
`timescale 1ns/100ps
module tdda_chan
  import tdda_pkg::*;
#(
  parameter int unsigned CHAN_ID = 0                   // dma channel number
) (
  input  wire logic                   ref_clk,         // processor clock, 40 mhz
  input  wire logic                   resetn,          // synchronous reset, low active
  input  wire logic [TDDA_REG_AW-1:0] reg_addr,        // register word offset
  input  wire logic [TDDA_DATA_W-1:0] reg_wdata,       // register write data
  input  wire logic                   reg_wr,          // write strobe
  input  wire logic                   reg_rd,          // read strobe
  output logic      [TDDA_DATA_W-1:0] reg_rdata,       // read data, cycle after strobe
  input  wire logic                   dma_grant,       // internal dma grant
  output logic                        dma_req,         // internal dma request
  output logic      [TDDA_ADDR_W-1:0] mem_addr,        // element address
  output logic                        mem_cycle,       // memory cycle pulse
  output logic                        row_change,      // row-change cycle pulse
  output logic                        block_done,      // end of block pulse
  output logic      [TDDA_ADDR_W-1:0] chain_ptr        // parameter set of next block
);

  // channel role is fixed at build time
  localparam logic TWO_DIM_OK = (CHAN_ID <= TDDA_LAST_2D_CHAN);
  localparam logic IS_LINK    = (CHAN_ID >= TDDA_FIRST_LINK_CHAN);

  localparam tdda_state_t RST_STATE = '{
    index_address:        TDDA_RST_ADDR,
    x_step_offset:        TDDA_RST_ADDR,
    x_count:              TDDA_RST_CNT,
    x_reload_value:       TDDA_RST_CNT,
    y_step_offset:        TDDA_RST_ADDR,
    rows_left:            TDDA_RST_CNT,
    next_param_pointer:   TDDA_RST_ADDR,
    link_two_dim_enable:  1'b0,
    sport_two_dim_enable: 1'b0,
    phase:                TDDA_IDLE,
    mem_addr:             TDDA_RST_ADDR,
    mem_cycle:            1'b0,
    row_cycle:            1'b0,
    block_done:           1'b0,
    dma_req:              1'b0,
    rdata:                TDDA_RST_DATA
  };

  // state copies and the wiring of the shared step unit
  tdda_state_t            q;
  tdda_state_t            d;
  logic                   two_dim;
  logic [TDDA_ADDR_W-1:0] st_step;
  logic [TDDA_CNT_W-1:0]  st_count;
  logic [TDDA_ADDR_W-1:0] st_sum;
  logic [TDDA_CNT_W-1:0]  st_count_dec;
  logic                   st_dec_zero;

  // the port kind picks which enable bit counts; high link channels ignore both
  assign two_dim = TWO_DIM_OK &&
                   (IS_LINK ? q.link_two_dim_enable : q.sport_two_dim_enable);

  // element cycles step along the row, row-change cycles step to the next row
  assign st_step  = (q.phase == TDDA_ROWCHG) ? q.y_step_offset : q.x_step_offset;
  assign st_count = (q.phase == TDDA_ROWCHG) ? q.rows_left : q.x_count;

  tdda_step u_step (
    .base      (q.index_address),
    .step      (st_step),
    .count     (st_count),
    .sum       (st_sum),
    .count_dec (st_count_dec),
    .dec_zero  (st_dec_zero)
  );

  // next-state logic: sequencer first, then software access on top of it
  always_comb begin
    d            = q;
    d.mem_cycle  = 1'b0;
    d.row_cycle  = 1'b0;
    d.block_done = 1'b0;
    d.rdata      = TDDA_RST_DATA;

    case (q.phase)
      TDDA_IDLE: begin
        // a grant arriving while idle is ignored; only a pointer write restarts
        d.phase = TDDA_IDLE;
      end
      TDDA_ELEM: begin
        // nothing moves without a grant, so a stalled port loses no element
        if (dma_grant) begin
          d.mem_addr      = q.index_address;
          d.mem_cycle     = 1'b1;
          d.index_address = st_sum;
          d.x_count       = st_count_dec;
          // last element of a row: change rows in 2-d mode, otherwise the block ends
          if (st_dec_zero) begin
            if (two_dim) begin
              d.phase = TDDA_ROWCHG;
            end else begin
              d.phase      = TDDA_IDLE;
              d.block_done = 1'b1;
            end
          end
        end
      end
      TDDA_ROWCHG: begin
        // the row change costs a dma cycle of its own, hence also granted
        if (dma_grant) begin
          d.x_count       = q.x_reload_value;
          d.index_address = st_sum;
          d.rows_left     = st_count_dec;
          d.row_cycle     = 1'b1;
          if (st_dec_zero) begin
            d.phase      = TDDA_IDLE;
            d.block_done = 1'b1;
          end else begin
            d.phase = TDDA_ELEM;
          end
        end
      end
      default: begin
        // an illegal phase code falls back to idle rather than running wild
        d.phase = TDDA_IDLE;
      end
    endcase

    // a software write wins over the sequencer for the register it names
    if (reg_wr) begin
      case (reg_addr)
        TDDA_OFF_INDEX: begin
          d.index_address = reg_wdata[TDDA_ADDR_W-1:0];
        end
        TDDA_OFF_XSTEP: begin
          d.x_step_offset = reg_wdata[TDDA_ADDR_W-1:0];
        end
        TDDA_OFF_XCNT: begin
          d.x_count        = reg_wdata[TDDA_CNT_W-1:0];
          d.x_reload_value = reg_wdata[TDDA_CNT_W-1:0];
        end
        TDDA_OFF_XRELD: begin
          d.x_reload_value = reg_wdata[TDDA_CNT_W-1:0];
        end
        TDDA_OFF_YSTEP: begin
          d.y_step_offset = reg_wdata[TDDA_ADDR_W-1:0];
        end
        TDDA_OFF_ROWS: begin
          d.rows_left = reg_wdata[TDDA_CNT_W-1:0];
        end
        TDDA_OFF_NPTR: begin
          // writing the pointer (re)starts the block with the loaded set
          d.next_param_pointer = reg_wdata[TDDA_ADDR_W-1:0];
          d.phase              = TDDA_ELEM;
        end
        TDDA_OFF_CTRL: begin
          d.link_two_dim_enable  = reg_wdata[TDDA_CTRL_LINK_2D_BIT];
          d.sport_two_dim_enable = reg_wdata[TDDA_CTRL_SPORT_2D_BIT];
        end
        default: begin
          // unmapped offsets are ignored, nothing to update
        end
      endcase
    end

    // read data is registered; unmapped offsets read as zero
    if (reg_rd) begin
      case (reg_addr)
        TDDA_OFF_INDEX:  d.rdata[TDDA_ADDR_W-1:0] = q.index_address;
        TDDA_OFF_XSTEP:  d.rdata[TDDA_ADDR_W-1:0] = q.x_step_offset;
        TDDA_OFF_XCNT:   d.rdata[TDDA_CNT_W-1:0]  = q.x_count;
        TDDA_OFF_XRELD:  d.rdata[TDDA_CNT_W-1:0]  = q.x_reload_value;
        TDDA_OFF_YSTEP:  d.rdata[TDDA_ADDR_W-1:0] = q.y_step_offset;
        TDDA_OFF_ROWS:   d.rdata[TDDA_CNT_W-1:0]  = q.rows_left;
        TDDA_OFF_NPTR:   d.rdata[TDDA_ADDR_W-1:0] = q.next_param_pointer;
        TDDA_OFF_CTRL: begin
          d.rdata[TDDA_CTRL_LINK_2D_BIT]  = q.link_two_dim_enable;
          d.rdata[TDDA_CTRL_SPORT_2D_BIT] = q.sport_two_dim_enable;
        end
        TDDA_OFF_STATUS: begin
          d.rdata[TDDA_STAT_ACTIVE_BIT] = (q.phase != TDDA_IDLE);
          d.rdata[TDDA_STAT_ROWCHG_BIT] = (q.phase == TDDA_ROWCHG);
        end
        default: begin
          d.rdata = TDDA_RST_DATA;
        end
      endcase
    end

    // request is kept in its own flop so the pin does not decode the phase
    d.dma_req = (d.phase != TDDA_IDLE);
  end

  // the only state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // every output is a field of the state register
  assign reg_rdata  = q.rdata;
  assign dma_req    = q.dma_req;
  assign mem_addr   = q.mem_addr;
  assign mem_cycle  = q.mem_cycle;
  assign row_change = q.row_cycle;
  assign block_done = q.block_done;
  assign chain_ptr  = q.next_param_pointer;

  // checks on the sequencer, read-only taps of the state register
  // they never drive anything, so they leave the netlist untouched
  // expected arithmetic results, truncated to the register width
  logic [TDDA_ADDR_W-1:0] exp_x_sum;
  logic [TDDA_ADDR_W-1:0] exp_y_sum;
  logic [TDDA_CNT_W-1:0]  exp_x_dec;
  logic [TDDA_CNT_W-1:0]  exp_y_dec;
  logic                   elem_go;
  logic                   row_go;

  assign exp_x_sum = q.index_address + q.x_step_offset;
  assign exp_y_sum = q.index_address + q.y_step_offset;
  assign exp_x_dec = q.x_count - 16'h0001;
  assign exp_y_dec = q.rows_left - 16'h0001;
  assign elem_go   = (q.phase == TDDA_ELEM) && dma_grant && !reg_wr;
  assign row_go    = (q.phase == TDDA_ROWCHG) && dma_grant && !reg_wr;

  // all checks run on the one clock and sleep while reset is held
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_elem_address: assert property (
    ((q.phase == TDDA_ELEM) && dma_grant) |=> (mem_cycle && (mem_addr == $past(q.index_address)))
  ) else $error("element cycle did not present the index address");

  a_first_unmodified: assert property (
    (reg_wr && (reg_addr == TDDA_OFF_NPTR)) ##1 ((q.phase == TDDA_ELEM) && dma_grant && !reg_wr)
    |=> (mem_addr == $past(q.index_address, 1))
  ) else $error("first transfer used a modified address");

  a_x_step_add: assert property (
    elem_go |=> (q.index_address == $past(exp_x_sum))
  ) else $error("column step not added in element cycle");

  a_x_count_dec: assert property (
    elem_go |=> (q.x_count == $past(exp_x_dec))
  ) else $error("element count not decremented");

  a_row_entry: assert property (
    (elem_go && (q.x_count == 16'h0001) && two_dim) |=> (q.phase == TDDA_ROWCHG)
  ) else $error("row end did not enter row-change cycle");

  a_no_extra_cycle: assert property (
    (elem_go && (q.x_count != 16'h0001)) |=> (q.phase == TDDA_ELEM)
  ) else $error("extra cycle taken inside a row");

  a_x_reload: assert property (
    row_go |=> ((q.x_count == $past(q.x_reload_value)) && row_change)
  ) else $error("element count not reloaded on row change");

  a_y_step_add: assert property (
    row_go |=> (q.index_address == $past(exp_y_sum))
  ) else $error("row step not added in row-change cycle");

  a_rows_dec: assert property (
    row_go |=> (q.rows_left == $past(exp_y_dec))
  ) else $error("row count not decremented");

  a_block_end: assert property (
    (row_go && (q.rows_left == 16'h0001))
    |=> (block_done && !dma_req) ##1 (!block_done && (q.phase == TDDA_IDLE))
  ) else $error("block did not end when rows ran out");

  a_idle_holds: assert property (
    ((q.phase == TDDA_IDLE) && !(reg_wr && (reg_addr == TDDA_OFF_NPTR)))
    |=> ((q.phase == TDDA_IDLE) && !mem_cycle)
  ) else $error("channel left idle without a pointer write");

  a_zero_moves: assert property (
    (reg_wr && (reg_addr == TDDA_OFF_NPTR)) ##1 (dma_grant && !reg_wr) |=> mem_cycle
  ) else $error("started channel moved no element");

  a_reload_copy: assert property (
    (reg_wr && (reg_addr == TDDA_OFF_XCNT))
    |=> (q.x_reload_value == $past(reg_wdata[TDDA_CNT_W-1:0]))
  ) else $error("element count write not copied to reload value");

  a_high_chan_1d: assert property (
    ((q.phase == TDDA_ELEM) ##1 (q.phase == TDDA_ROWCHG))
    |-> $past(two_dim)
  ) else $error("row change on a channel without two-dimensional mode");

  a_mode_off_1d: assert property (
    (elem_go && (q.x_count == 16'h0001) && !two_dim) |=> (block_done && (q.phase == TDDA_IDLE))
  ) else $error("one-dimensional channel took a row change");

  a_pointer_kept: assert property (
    (reg_wr && (reg_addr == TDDA_OFF_NPTR))
    |=> (chain_ptr == $past(reg_wdata[TDDA_ADDR_W-1:0]))
  ) else $error("next parameter pointer not held");

  a_hold_no_grant: assert property (
    ((q.phase != TDDA_IDLE) && !dma_grant && !reg_wr)
    |=> ($stable(q.index_address) && $stable(q.x_count) && $stable(q.rows_left) && !mem_cycle)
  ) else $error("state moved without a grant");

  a_row_no_mem: assert property (
    row_go |=> (!mem_cycle && $stable(mem_addr))
  ) else $error("row-change cycle started a memory cycle");

  a_rows_hold_elem: assert property (
    elem_go |=> $stable(q.rows_left)
  ) else $error("row count moved in an element cycle");

  a_req_tracks: assert property (
    dma_req == (q.phase != TDDA_IDLE)
  ) else $error("dma request does not follow the block state");

  // scenarios worth seeing at least once
  c_row_change: cover property (row_go ##1 (q.phase == TDDA_ELEM));
  c_block_done: cover property (row_go ##1 block_done);
  c_stall:      cover property (((q.phase == TDDA_ELEM) && !dma_grant) ##1 elem_go);
  c_zero_count: cover property ((q.x_count == TDDA_RST_CNT) && elem_go);

endmodule

// File: verification/tdda_grant_model.sv
`timescale 1ns/100ps
// far-side dma controller: grants the channel every cycle or with random stalls
module tdda_grant_model
  import tdda_pkg::*;
(
  input  wire logic ref_clk,   // processor clock
  input  wire logic resetn,    // synchronous reset, low active
  input  wire logic dma_req,   // request from the channel
  input  wire logic slow,      // insert random stall cycles
  output logic      dma_grant  // grant to the channel
);
  // fast mode keeps the grant high even when idle, so a finished block must ignore it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dma_grant <= 1'b0;
    end else begin
      dma_grant <= slow ? (dma_req && ($urandom_range(3) != 0)) : 1'b1;
    end
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/100ps
// self-checking bench for one channel of the two-dimensional address sequencer
module testbench
  import tdda_pkg::*;
;
  logic                   ref_clk;
  logic                   resetn;
  logic                   reg_wr;
  logic                   reg_rd;
  logic                   dma_grant;
  logic                   dma_req;
  logic                   mem_cycle;
  logic                   row_change;
  logic                   block_done;
  logic                   slow;
  logic                   rd_d;
  logic                   done_seen;
  logic [TDDA_REG_AW-1:0] reg_addr;
  logic [TDDA_DATA_W-1:0] reg_wdata;
  logic [TDDA_DATA_W-1:0] reg_rdata;
  logic [TDDA_ADDR_W-1:0] mem_addr;
  logic [TDDA_ADDR_W-1:0] chain_ptr;
  logic [TDDA_DATA_W-1:0] rd_q[$];
  logic [TDDA_ADDR_W-1:0] addr_q[$];
  int                     fail_count;
  int                     checked;
  int                     rows_seen;
  // block shapes: elements per row, rows, mode bits, stalling grant
  int                     ncnt[6] = '{2, 3, 4, 3, 1, 0};
  int                     nrow[6] = '{2, 4, 1, 5, 3, 1};
  logic [1:0]             ctl[6]  = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h3, 2'h2};
  logic                   stl[6]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  tdda_chan tdda_chan_i (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .dma_grant  (dma_grant),
    .dma_req    (dma_req),
    .mem_addr   (mem_addr),
    .mem_cycle  (mem_cycle),
    .row_change (row_change),
    .block_done (block_done),
    .chain_ptr  (chain_ptr)
  );

  tdda_grant_model tdda_grant_model_i (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .dma_req   (dma_req),
    .slow      (slow),
    .dma_grant (dma_grant)
  );

  // 40 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one strobe per call; for a read, d is the expected data and goes on the queue
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    if (!w) rd_q.push_back(d);
  endtask

  task automatic idle;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // program one block, predict its address stream, run it and read back the end state
  task automatic run(input int n, input int m, input logic [1:0] c, input logic s);
    logic [18:0] ia;
    logic [18:0] xs;
    logic [18:0] ys;
    logic [18:0] ptr;
    logic [18:0] a;
    logic        two_d;
    int          elems;
    int          rows;
    ia    = 19'($urandom);
    xs    = 19'($urandom_range(64));
    ys    = 19'($urandom);
    ptr   = 19'($urandom);
    two_d = c[1];                        // channel 0 follows the serial port bit
    elems = (n == 0) ? 65536 : n;        // a zero count wraps instead of skipping
    rows  = two_d ? m : 1;
    a     = ia;
    for (int r = 0; r < rows; r++) begin
      for (int e = 0; e < elems; e++) begin
        addr_q.push_back(a);
        a = a + xs;
      end
      if (two_d) a = a + ys;
    end
    slow      <= s;
    rows_seen = 0;
    done_seen = 1'b0;
    bus(1'b1, TDDA_OFF_INDEX, 32'(ia));
    bus(1'b1, TDDA_OFF_XSTEP, 32'(xs));
    bus(1'b1, TDDA_OFF_XRELD, 32'h0000_5555);
    bus(1'b1, TDDA_OFF_XCNT, 32'(n));
    bus(1'b1, TDDA_OFF_YSTEP, 32'(ys));
    bus(1'b1, TDDA_OFF_ROWS, 32'(m));      // one row gives a plain linear block
    bus(1'b1, TDDA_OFF_CTRL, 32'(c));
    bus(1'b0, TDDA_OFF_XRELD, 32'(n));
    bus(1'b1, TDDA_OFF_NPTR, 32'(ptr));
    bus(1'b0, TDDA_OFF_STATUS, 32'h0000_0001);
    idle;
    for (int t = 0; t < 70000 && !done_seen; t++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk(32'(done_seen), 32'h0000_0001, "block_done");
    chk(32'(addr_q.size()), 32'h0000_0000, "elements left");
    chk(32'(rows_seen), two_d ? 32'(m) : 32'h0000_0000, "row changes");
    chk(32'(dma_req), 32'h0000_0000, "dma_req");
    chk(32'(chain_ptr), 32'(ptr), "chain_ptr");
    bus(1'b0, TDDA_OFF_INDEX, 32'(a));
    bus(1'b0, TDDA_OFF_XCNT, two_d ? 32'(n) : 32'h0000_0000);
    bus(1'b0, TDDA_OFF_ROWS, two_d ? 32'h0000_0000 : 32'(m));
    bus(1'b0, TDDA_OFF_STATUS, 32'h0000_0000);
    idle;
  endtask

  // read strobe seen at an edge means read data stands in the following cycle
  always @(posedge ref_clk) rd_d <= reg_rd;

  // results taken at the falling edge, where registered outputs have settled
  always @(negedge ref_clk) begin
    if (rd_d) chk(reg_rdata, rd_q.pop_front(), "reg_rdata");
    if (mem_cycle) begin
      if (addr_q.size() == 0) chk(32'h0000_0001, 32'h0000_0000, "extra mem_cycle");
      else chk(32'(mem_addr), 32'(addr_q.pop_front()), "mem_addr");
    end
    if (row_change) rows_seen++;
    if (block_done) done_seen = 1'b1;
  end

  // main sequence: reset, reset values and unmapped offset, then the block table
  initial begin
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0000_0000;
    resetn     = 1'b0;
    slow       = 1'b0;
    rd_d       = 1'b0;
    done_seen  = 1'b0;
    fail_count = 0;
    checked    = 0;
    rows_seen  = 0;
    void'($urandom(49));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 10; a++) bus(1'b0, 4'(a), 32'h0000_0000);
    idle;
    for (int k = 0; k < 6; k++) run(ncnt[k], nrow[k], ctl[k], stl[k]);
    repeat (2) @(posedge ref_clk);
    end_sim;
  end

  // watchdog: the longest block takes about 65 600 cycles, so 90 000 means a hang
  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    end_sim;
  end
endmodule
